// >>> idm_pkg.sv
// internal data memory decoder: shared constants, types and helpers
// assumes a single clock domain and an 8-bit data-memory address space
package idm_pkg;

  localparam int unsigned RAM_DEPTH = 256;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [7:0] LOWER_TOP = 8'h7f;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [7:0] BANK_BASE = 8'h00;
  localparam logic [7:0] BANK_TOP = 8'h1f;
  localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
  localparam logic [7:0] BIT_BYTE_TOP = 8'h2f;
  localparam logic [7:0] BIT_LOW_TOP = 8'h7f;

  localparam logic [7:0] STACK_PTR_ADDR = 8'h81;
  localparam logic [7:0] STACK_PTR_RESET = 8'h07;

  localparam int unsigned BANK_SEL_LOW_POS = 3;
  localparam int unsigned BANK_SEL_HIGH_POS = 4;

  localparam int unsigned REC_W = 32;
  localparam int unsigned REC_CNT_W = 6;
  localparam logic [5:0] REC_DEPTH_MAX = 6'h20;
  localparam logic [5:0] REC_DEPTH_RESET = 6'h00;
  localparam logic [31:0] REC_RESET = 32'h0000_0000;

  typedef enum logic [3:0] {
    OP_DIR   = 4'h0,
    OP_IND   = 4'h1,
    OP_BIT   = 4'h2,
    OP_REG   = 4'h3,
    OP_PUSH  = 4'h4,
    OP_POP   = 4'h5,
    OP_CALL  = 4'h6,
    OP_RET   = 4'h7,
    OP_SPINC = 4'h8,
    OP_SPDEC = 4'h9
  } idm_op_e;

  typedef enum logic [1:0] {
    SRC_RAM = 2'h0,
    SRC_SFR = 2'h1,
    SRC_SP  = 2'h2
  } idm_src_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_PTR   = 3'h1,
    ST_RD    = 3'h3,
    ST_CALL2 = 3'h2,
    ST_RET2  = 3'h6
  } idm_state_e;

  // byte address holding a given bit address
  function automatic logic [7:0] idm_bit_byte(input logic [7:0] bit_addr);
    if (bit_addr[7]) begin
      idm_bit_byte = {bit_addr[7:3], 3'h0};
    end else begin
      idm_bit_byte = BIT_BYTE_BASE + {4'h0, bit_addr[6:3]};
    end
  endfunction

  // address of register n of the active bank
  function automatic logic [7:0] idm_bank_reg(input logic [1:0] bank, input logic [2:0] num);
    idm_bank_reg = BANK_BASE | {3'h0, bank, num};
  endfunction

endpackage

// >>> idm_ram.sv
// 256 x 8 internal data storage, one port, registered read data
// assumes one access per clock from the decoder on the same clock
`timescale 1ns/1ps
module idm_ram
  import idm_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] ram_addr,
  input  wire logic       ram_we,
  input  wire logic [7:0] ram_wdata,
  output logic      [7:0] ram_rdata
);

  logic [7:0] mem [RAM_DEPTH];

  always_ff @(posedge ref_clk) begin
    if (ram_we) begin
      mem[ram_addr] <= ram_wdata;
    end
    ram_rdata <= mem[ram_addr];
  end

endmodule

// >>> idm_stack_rec.sv
// 32-bit stack record shift register with overflow/underflow flags
// assumes at most one push or pop event per clock
`timescale 1ns/1ps
module idm_stack_rec
  import idm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        rec_push1,
  input  wire logic        rec_push2,
  input  wire logic        rec_pop1,
  input  wire logic        rec_pop2,
  input  wire logic        dbg_clear,
  output logic      [31:0] rec_bits,
  output logic      [5:0]  rec_depth,
  output logic             rec_overflow,
  output logic             rec_underflow
);

  logic [31:0] bits_next;
  logic [5:0]  depth_next;
  logic        ovf_next;
  logic        udf_next;
  logic [5:0]  room;

  always_comb begin
    bits_next = rec_bits;
    depth_next = rec_depth;
    ovf_next = rec_overflow & ~dbg_clear;
    udf_next = rec_underflow & ~dbg_clear;
    room = REC_DEPTH_MAX - rec_depth;
    if (rec_push1) begin
      bits_next = {rec_bits[30:0], 1'b0};
      if (room == 6'h00) begin
        ovf_next = 1'b1;
      end else begin
        depth_next = rec_depth + 6'h01;
      end
    end else if (rec_push2) begin
      bits_next = {rec_bits[29:0], 2'b11};
      if (room < 6'h02) begin
        ovf_next = 1'b1;
        depth_next = REC_DEPTH_MAX;
      end else begin
        depth_next = rec_depth + 6'h02;
      end
    end else if (rec_pop1) begin
      bits_next = {1'b0, rec_bits[31:1]};
      if (rec_depth == 6'h00) begin
        udf_next = 1'b1;
      end else begin
        depth_next = rec_depth - 6'h01;
      end
    end else if (rec_pop2) begin
      bits_next = {2'b00, rec_bits[31:2]};
      if (rec_depth < 6'h02) begin
        udf_next = 1'b1;
        depth_next = REC_DEPTH_RESET;
      end else begin
        depth_next = rec_depth - 6'h02;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rec_bits <= REC_RESET;
      rec_depth <= REC_DEPTH_RESET;
      rec_overflow <= 1'b0;
      rec_underflow <= 1'b0;
    end else begin
      rec_bits <= bits_next;
      rec_depth <= depth_next;
      rec_overflow <= ovf_next;
      rec_underflow <= udf_next;
    end
  end

endmodule

// >>> idm_decoder.sv
// internal data memory decoder: banks, bit area, upper ram, sfr split, stack
// assumes the core issues one request when op_ready is high, on ref_clk
`timescale 1ns/1ps
module idm_decoder
  import idm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        op_valid,
  input  wire logic [3:0]  op_kind,
  input  wire logic        op_write,
  input  wire logic [7:0]  op_addr,
  input  wire logic [15:0] op_wdata,
  input  wire logic        op_wbit,
  input  wire logic [7:0]  program_status_word,
  output logic             op_ready,
  output logic             op_done,
  output logic      [15:0] op_rdata,
  output logic             op_rbit,
  output logic      [7:0]  sfr_addr,
  output logic             sfr_rd,
  output logic             sfr_wr,
  output logic      [7:0]  sfr_wdata,
  input  wire logic [7:0]  sfr_rdata,
  output logic      [7:0]  stack_top_pointer,
  input  wire logic        dbg_clear,
  output logic      [31:0] rec_bits,
  output logic      [5:0]  rec_depth,
  output logic             rec_overflow,
  output logic             rec_underflow
);

  idm_state_e  state_reg;
  idm_state_e  state_next;
  idm_op_e     kind_reg;
  idm_op_e     kind_next;
  idm_src_e    src_reg;
  idm_src_e    src_next;
  logic [7:0]  sp_next;
  logic [7:0]  addr_reg;
  logic [7:0]  addr_next;
  logic [2:0]  pos_reg;
  logic [2:0]  pos_next;
  logic        write_reg;
  logic        write_next;
  logic        wbit_reg;
  logic        wbit_next;
  logic [7:0]  data_reg;
  logic [7:0]  data_next;
  logic [7:0]  hi_reg;
  logic [7:0]  hi_next;
  logic [15:0] rdata_next;
  logic        rbit_next;
  logic        done_next;
  logic [7:0]  ram_addr;
  logic        ram_we;
  logic [7:0]  ram_wdata;
  logic [7:0]  ram_rdata;
  logic [7:0]  got;
  logic [7:0]  modified;
  logic [1:0]  bank;
  logic        rec_push1;
  logic        rec_push2;
  logic        rec_pop1;
  logic        rec_pop2;

  assign bank = {program_status_word[BANK_SEL_HIGH_POS],
                 program_status_word[BANK_SEL_LOW_POS]};
  assign op_ready = (state_reg == ST_IDLE);

  idm_ram u_ram (
    .ref_clk   (ref_clk),
    .ram_addr  (ram_addr),
    .ram_we    (ram_we),
    .ram_wdata (ram_wdata),
    .ram_rdata (ram_rdata)
  );

  idm_stack_rec u_rec (
    .ref_clk       (ref_clk),
    .rst_b         (rst_b),
    .rec_push1     (rec_push1),
    .rec_push2     (rec_push2),
    .rec_pop1      (rec_pop1),
    .rec_pop2      (rec_pop2),
    .dbg_clear     (dbg_clear),
    .rec_bits      (rec_bits),
    .rec_depth     (rec_depth),
    .rec_overflow  (rec_overflow),
    .rec_underflow (rec_underflow)
  );

  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    src_next = src_reg;
    sp_next = stack_top_pointer;
    addr_next = addr_reg;
    pos_next = pos_reg;
    write_next = write_reg;
    wbit_next = wbit_reg;
    data_next = data_reg;
    hi_next = hi_reg;
    rdata_next = op_rdata;
    rbit_next = op_rbit;
    done_next = 1'b0;
    ram_addr = 8'h00;
    ram_we = 1'b0;
    ram_wdata = 8'h00;
    sfr_addr = 8'h00;
    sfr_rd = 1'b0;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    rec_push1 = 1'b0;
    rec_push2 = 1'b0;
    rec_pop1 = 1'b0;
    rec_pop2 = 1'b0;
    got = 8'h00;
    modified = 8'h00;
    unique case (state_reg)
      ST_IDLE: begin
        if (op_valid) begin
          kind_next = idm_op_e'(op_kind);
          write_next = op_write;
          wbit_next = op_wbit;
          data_next = op_wdata[7:0];
          hi_next = op_wdata[15:8];
          src_next = SRC_RAM;
          case (idm_op_e'(op_kind))
            OP_DIR: begin
              addr_next = op_addr;
              if (op_addr == STACK_PTR_ADDR) begin
                src_next = SRC_SP;
                if (op_write) begin
                  sp_next = op_wdata[7:0];
                end
              end else if (op_addr >= UPPER_BASE) begin
                src_next = SRC_SFR;
                sfr_addr = op_addr;
                sfr_rd = ~op_write;
                sfr_wr = op_write;
                sfr_wdata = op_wdata[7:0];
              end else begin
                ram_addr = op_addr;
                ram_we = op_write;
                ram_wdata = op_wdata[7:0];
              end
              done_next = op_write;
              state_next = op_write ? ST_IDLE : ST_RD;
            end
            OP_REG: begin
              ram_addr = idm_bank_reg(bank, op_addr[2:0]);
              ram_we = op_write;
              ram_wdata = op_wdata[7:0];
              done_next = op_write;
              state_next = op_write ? ST_IDLE : ST_RD;
            end
            OP_IND: begin
              ram_addr = idm_bank_reg(bank, {2'h0, op_addr[0]});
              state_next = ST_PTR;
            end
            OP_BIT: begin
              addr_next = idm_bit_byte(op_addr);
              pos_next = op_addr[2:0];
              if (op_addr[7]) begin
                src_next = SRC_SFR;
                sfr_addr = idm_bit_byte(op_addr);
                sfr_rd = 1'b1;
              end else begin
                ram_addr = idm_bit_byte(op_addr);
              end
              state_next = ST_RD;
            end
            OP_PUSH: begin
              ram_addr = stack_top_pointer + 8'h01;
              ram_we = 1'b1;
              ram_wdata = op_wdata[7:0];
              sp_next = stack_top_pointer + 8'h01;
              rec_push1 = 1'b1;
              done_next = 1'b1;
            end
            OP_POP: begin
              ram_addr = stack_top_pointer;
              sp_next = stack_top_pointer - 8'h01;
              rec_pop1 = 1'b1;
              state_next = ST_RD;
            end
            OP_CALL: begin
              ram_addr = stack_top_pointer + 8'h01;
              ram_we = 1'b1;
              ram_wdata = op_wdata[7:0];
              sp_next = stack_top_pointer + 8'h01;
              rec_push2 = 1'b1;
              state_next = ST_CALL2;
            end
            OP_RET: begin
              ram_addr = stack_top_pointer;
              sp_next = stack_top_pointer - 8'h01;
              rec_pop2 = 1'b1;
              state_next = ST_RET2;
            end
            OP_SPINC: begin
              sp_next = stack_top_pointer + 8'h01;
              rec_push1 = 1'b1;
              done_next = 1'b1;
            end
            OP_SPDEC: begin
              sp_next = stack_top_pointer - 8'h01;
              rec_pop1 = 1'b1;
              done_next = 1'b1;
            end
            default: begin
              done_next = 1'b1;
            end
          endcase
        end
      end
      ST_PTR: begin
        addr_next = ram_rdata;
        ram_addr = ram_rdata;
        ram_we = write_reg;
        ram_wdata = data_reg;
        done_next = write_reg;
        state_next = write_reg ? ST_IDLE : ST_RD;
      end
      ST_RET2: begin
        hi_next = ram_rdata;
        ram_addr = stack_top_pointer;
        sp_next = stack_top_pointer - 8'h01;
        state_next = ST_RD;
      end
      ST_CALL2: begin
        ram_addr = stack_top_pointer + 8'h01;
        ram_we = 1'b1;
        ram_wdata = hi_reg;
        sp_next = stack_top_pointer + 8'h01;
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
      ST_RD: begin
        unique case (src_reg)
          SRC_SFR: got = sfr_rdata;
          SRC_SP:  got = stack_top_pointer;
          default: got = ram_rdata;
        endcase
        if (kind_reg == OP_BIT) begin
          modified = got;
          modified[pos_reg] = wbit_reg;
          rbit_next = got[pos_reg];
          if (write_reg) begin
            if (src_reg == SRC_SFR) begin
              sfr_addr = addr_reg;
              sfr_wr = 1'b1;
              sfr_wdata = modified;
            end else begin
              ram_addr = addr_reg;
              ram_we = 1'b1;
              ram_wdata = modified;
            end
          end
        end else if (kind_reg == OP_RET) begin
          rdata_next = {hi_reg, got};
        end else begin
          rdata_next = {8'h00, got};
        end
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      kind_reg <= OP_DIR;
      src_reg <= SRC_RAM;
      stack_top_pointer <= STACK_PTR_RESET;
      addr_reg <= 8'h00;
      pos_reg <= 3'h0;
      write_reg <= 1'b0;
      wbit_reg <= 1'b0;
      data_reg <= 8'h00;
      hi_reg <= 8'h00;
      op_rdata <= 16'h0000;
      op_rbit <= 1'b0;
      op_done <= 1'b0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      src_reg <= src_next;
      stack_top_pointer <= sp_next;
      addr_reg <= addr_next;
      pos_reg <= pos_next;
      write_reg <= write_next;
      wbit_reg <= wbit_next;
      data_reg <= data_next;
      hi_reg <= hi_next;
      op_rdata <= rdata_next;
      op_rbit <= rbit_next;
      op_done <= done_next;
    end
  end

endmodule

// >>> idm_decoder_asserts.sv
// checker for idm_decoder: stack, record and sfr routing timing
// assumes binding to idm_decoder on the single ref_clk domain
`timescale 1ns/1ps
module idm_decoder_asserts
  import idm_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        op_valid,
  input wire logic [3:0]  op_kind,
  input wire logic        op_write,
  input wire logic [7:0]  op_addr,
  input wire logic        op_ready,
  input wire logic        op_done,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_rd,
  input wire logic        sfr_wr,
  input wire logic [7:0]  stack_top_pointer,
  input wire logic [31:0] rec_bits,
  input wire logic [5:0]  rec_depth,
  input wire logic        rec_overflow,
  input wire logic        rec_underflow
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_take(logic [3:0] k);
    op_valid && op_ready && op_kind == k;
  endsequence

  a_push_sp_step: assert property (
    s_take(OP_PUSH) |=> op_done && stack_top_pointer == $past(stack_top_pointer) + 8'h01)
    else $error("push did not advance stack pointer by one");
  a_call_sp_two: assert property (
    s_take(OP_CALL) |-> ##2 op_done && stack_top_pointer == $past(stack_top_pointer, 2) + 8'h02)
    else $error("call did not advance stack pointer by two");
  a_push_rec_shift: assert property (
    s_take(OP_PUSH) ##0 rec_depth < 6'h20 |=> rec_depth == $past(rec_depth) + 6'h01
      && rec_bits == {$past(rec_bits[30:0]), 1'b0})
    else $error("push did not shift one record bit");
  a_call_rec_two: assert property (
    s_take(OP_CALL) ##0 rec_depth < 6'h1f |-> ##2 rec_depth == $past(rec_depth, 2) + 6'h02
      && rec_bits[1:0] == 2'b11)
    else $error("call did not shift two record bits");
  a_ret_rec_two: assert property (
    s_take(OP_RET) ##0 rec_depth > 6'h01 |-> ##3 rec_depth == $past(rec_depth, 3) - 6'h02)
    else $error("return did not drop two record bits");
  a_spdec_rec_one: assert property (
    s_take(OP_SPDEC) ##0 rec_depth != 6'h00 |=> rec_depth == $past(rec_depth) - 6'h01)
    else $error("pointer decrement did not drop one record bit");
  a_rec_overflow_flag: assert property (
    s_take(OP_SPINC) ##0 rec_depth == REC_DEPTH_MAX |=> rec_overflow)
    else $error("record overflow not flagged");
  a_rec_underflow_flag: assert property (
    s_take(OP_POP) ##0 rec_depth == 6'h00 |-> ##2 rec_underflow)
    else $error("record underflow not flagged");
  a_direct_high_sfr: assert property (
    s_take(OP_DIR) ##0 (op_addr[7] && op_addr != STACK_PTR_ADDR) |-> sfr_addr == op_addr
      && sfr_wr == op_write && sfr_rd == !op_write)
    else $error("direct high access not routed to sfr space");
  a_indirect_no_sfr: assert property (
    s_take(OP_IND) |-> (!sfr_rd && !sfr_wr) [*3])
    else $error("indirect access touched sfr space");
  a_sfr_bit_byte: assert property (
    s_take(OP_BIT) ##0 op_addr[7] |-> sfr_rd && sfr_addr == {op_addr[7:3], 3'h0})
    else $error("sfr bit address decoded to wrong byte");
  a_bit_two_cycle: assert property (
    s_take(OP_BIT) |=> !op_done ##1 op_done)
    else $error("bit access latency wrong");
endmodule

bind idm_decoder idm_decoder_asserts idm_decoder_asserts_i (
  .ref_clk, .rst_b, .op_valid, .op_kind, .op_write, .op_addr, .op_ready, .op_done,
  .sfr_addr, .sfr_rd, .sfr_wr, .stack_top_pointer, .rec_bits, .rec_depth,
  .rec_overflow, .rec_underflow
);

// >>> idm_sfr_model.sv
// sfr space model: byte registers behind the decoder's sfr strobes
// assumes read data is wanted one cycle after sfr_rd
`timescale 1ns/1ps
module idm_sfr_model
  import idm_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_rd,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata
);
  logic [7:0] regs [128];
  initial sfr_rdata = 8'h5a;
  always @(posedge ref_clk) begin
    if (sfr_wr) begin
      regs[sfr_addr[6:0]] <= sfr_wdata;
    end
    if (sfr_rd) begin
      sfr_rdata <= regs[sfr_addr[6:0]];
    end else begin
      sfr_rdata <= ~sfr_rdata;
    end
  end
endmodule

// >>> testbench.sv
// testbench for idm_decoder: core requests, sfr model on the far side
// assumes one request at a time, issued while op_ready is high
`timescale 1ns/1ps
module testbench
  import idm_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        op_valid = 1'b0;
  logic [3:0]  op_kind = 4'h0;
  logic        op_write = 1'b0;
  logic [7:0]  op_addr = 8'h00;
  logic [15:0] op_wdata = 16'h0000;
  logic        op_wbit = 1'b0;
  logic [7:0]  program_status_word = 8'h00;
  logic        dbg_clear = 1'b0;
  logic        op_ready, op_done, op_rbit, sfr_rd, sfr_wr, rec_overflow, rec_underflow;
  logic [15:0] op_rdata;
  logic [15:0] rd;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, stack_top_pointer;
  logic [31:0] rec_bits;
  logic [5:0]  rec_depth;
  int          failures = 0;
  int          n_checks = 0;
  int          cycles = 0;

  idm_decoder idm_decoder_i (.ref_clk, .rst_b, .op_valid, .op_kind, .op_write, .op_addr,
    .op_wdata, .op_wbit, .program_status_word, .op_ready, .op_done, .op_rdata, .op_rbit,
    .sfr_addr, .sfr_rd, .sfr_wr, .sfr_wdata, .sfr_rdata, .stack_top_pointer, .dbg_clear,
    .rec_bits, .rec_depth, .rec_overflow, .rec_underflow);
  idm_sfr_model idm_sfr_model_i (.ref_clk, .sfr_addr, .sfr_rd, .sfr_wr, .sfr_wdata,
    .sfr_rdata);

  always #10 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one request, held to the taking edge, then wait for op_done
  task automatic req(input logic [3:0] k, input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    int n;
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_write <= w;
    op_addr <= a;
    op_wdata <= d;
    op_wbit <= d[0];
    @(posedge ref_clk);
    op_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (op_done !== 1'b1 && n < 8);
    check(n < 8, 1'b1);
    rd = op_rdata;
  endtask

  task automatic set_bank(input logic [1:0] b);
    @(posedge ref_clk);
    program_status_word <= {3'h0, b, 3'h0};
  endtask

  task automatic t_reset();
    check(stack_top_pointer, STACK_PTR_RESET);
    check({rec_overflow, rec_underflow, rec_depth}, 8'h00);
  endtask

  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      set_bank(b[1:0]);
      req(OP_REG, 1'b1, 8'h05, {8'h00, 8'ha0 + 8'(b)});
      req(OP_DIR, 1'b0, 8'(b * 8 + 5), 16'h0000);
      check(rd, 16'h00a0 + 16'(b));
    end
  endtask

  task automatic t_indirect();
    logic [7:0] ptr [3] = '{8'h45, 8'hc5, 8'hff};
    set_bank(2'h2);
    for (int i = 0; i < 3; i++) begin
      req(OP_REG, 1'b1, 8'h01, {8'h00, ptr[i]});
      req(OP_IND, 1'b1, 8'h01, {8'h00, ~ptr[i]});
      req(OP_IND, 1'b0, 8'h01, 16'h0000);
      check(rd, {8'h00, ~ptr[i]});
    end
    req(OP_DIR, 1'b0, 8'h11, 16'h0000);
    check(rd, 16'h00ff);
    req(OP_DIR, 1'b0, 8'h45, 16'h0000);
    check(rd, 16'h00ba);
    req(OP_REG, 1'b1, 8'h00, 16'h0045);
    req(OP_IND, 1'b0, 8'h00, 16'h0000);
    check(rd, 16'h00ba);
    req(OP_DIR, 1'b1, 8'hc5, 16'h0011); // occupied sfr only
    req(OP_REG, 1'b1, 8'h01, 16'h00c5);
    req(OP_IND, 1'b0, 8'h01, 16'h0000);
    check(rd, 16'h003a);
    req(OP_DIR, 1'b0, 8'hc5, 16'h0000);
    check(rd, 16'h0011);
  endtask

  task automatic t_bits();
    req(OP_DIR, 1'b1, 8'h22, 16'h0000);
    req(OP_BIT, 1'b1, 8'h13, 16'h0001);
    req(OP_DIR, 1'b0, 8'h22, 16'h0000);
    check(rd, 16'h0008);
    req(OP_DIR, 1'b1, 8'h2f, 16'h0080);
    req(OP_BIT, 1'b0, 8'h7f, 16'h0000);
    check(op_rbit, 1'b1);
    req(OP_BIT, 1'b0, 8'h78, 16'h0000);
    check(op_rbit, 1'b0);
    req(OP_DIR, 1'b1, 8'h90, 16'h0000);
    req(OP_BIT, 1'b1, 8'h93, 16'h0001);
    req(OP_DIR, 1'b0, 8'h90, 16'h0000);
    check(rd, 16'h0008);
  endtask

  task automatic t_stack();
    req(OP_PUSH, 1'b0, 8'h00, 16'h00aa);
    check(stack_top_pointer, 8'h08);
    req(OP_CALL, 1'b0, 8'h00, 16'h2211);
    check(stack_top_pointer, 8'h0a);
    check({rec_depth, rec_bits[2:0]}, {6'h03, 3'b011});
    req(OP_DIR, 1'b0, 8'h09, 16'h0000);
    check(rd, 16'h0011);
    req(OP_RET, 1'b0, 8'h00, 16'h0000);
    check({rd, 2'h0, rec_depth}, {16'h2211, 8'h01});
    req(OP_POP, 1'b0, 8'h00, 16'h0000);
    check({rd, stack_top_pointer}, {16'h00aa, 8'h07});
    req(OP_DIR, 1'b1, STACK_PTR_ADDR, 16'h00f0);
    req(OP_DIR, 1'b0, STACK_PTR_ADDR, 16'h0000);
    check(rd, 16'h00f0);
    req(OP_PUSH, 1'b0, 8'h00, 16'h0055);
    req(OP_REG, 1'b1, 8'h01, 16'h00f1);
    req(OP_IND, 1'b0, 8'h01, 16'h0000);
    check(rd, 16'h0055);
    req(OP_POP, 1'b0, 8'h00, 16'h0000);
  endtask

  task automatic t_record();
    req(OP_POP, 1'b0, 8'h00, 16'h0000);
    check(rec_underflow, 1'b1);
    @(posedge ref_clk);
    dbg_clear <= 1'b1;
    @(posedge ref_clk);
    dbg_clear <= 1'b0;
    @(negedge ref_clk);
    check({rec_overflow, rec_underflow}, 2'b00);
    for (int i = 0; i < 32; i++) req(OP_SPINC, 1'b0, 8'h00, 16'h0000);
    check({rec_overflow, rec_depth}, {1'b0, 6'h20});
    req(OP_SPINC, 1'b0, 8'h00, 16'h0000);
    check(rec_overflow, 1'b1);
    for (int i = 0; i < 32; i++) req(OP_SPDEC, 1'b0, 8'h00, 16'h0000);
    check({rec_underflow, rec_depth}, 7'h00);
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(negedge ref_clk);
    t_reset();
    t_banks();
    t_indirect();
    t_bits();
    t_stack();
    t_record();
    report_and_stop();
  end
endmodule
